// *** pkg/iopcn_defs.svh ***
// constants for the port and change-notice block: widths, offsets, resets
// assumes inclusion by bare name from the package and the top module
`ifndef IOPCN_DEFS_SVH
`define IOPCN_DEFS_SVH

`define IOPCN_PORT_W       16
`define IOPCN_CN_W         30
`define IOPCN_CN_LO_W      16
`define IOPCN_CN_HI_W      14
`define IOPCN_ADDR_W       12
`define IOPCN_IRQ_W        1

`define IOPCN_OFS_DIR      12'h000
`define IOPCN_OFS_LATCH    12'h004
`define IOPCN_OFS_LEVEL    12'h008
`define IOPCN_OFS_ODC      12'h00c
`define IOPCN_OFS_ANCFG    12'h010
`define IOPCN_OFS_CNEN_LO  12'h014
`define IOPCN_OFS_CNEN_HI  12'h018
`define IOPCN_OFS_PU_LO    12'h01c
`define IOPCN_OFS_PU_HI    12'h020
`define IOPCN_OFS_STATUS   12'h024
`define IOPCN_OFS_MASK     12'h028

`define IOPCN_RST_DIR      16'hffff
`define IOPCN_RST_LATCH    16'h0000
`define IOPCN_RST_ODC      16'h0000
`define IOPCN_RST_ANCFG    16'h0000
`define IOPCN_RST_CN_LO    16'h0000
`define IOPCN_RST_CN_HI    14'h0000
`define IOPCN_RST_IRQ      1'h0
`define IOPCN_IRQ_CN_BIT   0

`endif

// *** pkg/iopcn_pkg.sv ***
// types shared by the port and change-notice block
// assumes the constants header sits on the include path
`include "iopcn_defs.svh"

package iopcn_pkg;

  typedef struct packed {
    logic                       sel;
    logic                       en;
    logic                       write;
    logic [`IOPCN_ADDR_W-1:0]   addr;
    logic [31:0]                wdata;
  } iopcn_apb_req_t;

  typedef struct packed {
    logic [`IOPCN_PORT_W-1:0]   out;
    logic [`IOPCN_PORT_W-1:0]   oe;
  } iopcn_pad_t;

endpackage

// *** rtl/iopcn_top.sv ***
// port pin control, analog pin routing and input change notification
// assumes an apb master on the same clock and pads resolved outside
// Behaviour
// - open-drain bit set makes the pin drive low only, never high.
// - analog pin set to output feeds its driven level to the converter.
// - analog pin configuration resets to zero, all shared pins analog.
// - readback returns zero for every pin configured as analog input.
// - digital input pins are never connected to the converter.
// - an enabled change-notice pin changing state raises an interrupt.
// - change detection is not gated by sleep or any power state.
// - thirty change-notice inputs are supported.
// - two enable registers, one bit per change-notice pin.
// - two pull-up registers, one bit per pin, set turns pull-up on.
`timescale 1ns/1ns
`include "iopcn_defs.svh"

module iopcn_top (
  input  wire logic                        clock,
  input  wire logic                        srst,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [`IOPCN_ADDR_W-1:0]    paddr,
  input  wire logic [31:0]                 pwdata,
  output logic      [31:0]                 prdata,
  output logic                             pready,
  output logic                             pslverr,
  input  wire logic [`IOPCN_PORT_W-1:0]    pad_in,
  output logic      [`IOPCN_PORT_W-1:0]    pad_out,
  output logic      [`IOPCN_PORT_W-1:0]    pad_oe,
  output logic      [`IOPCN_PORT_W-1:0]    adc_connect,
  output logic      [`IOPCN_PORT_W-1:0]    adc_use_driven,
  output logic      [`IOPCN_PORT_W-1:0]    adc_driven_level,
  input  wire logic [`IOPCN_CN_W-1:0]      change_notice_input,
  output logic      [`IOPCN_CN_W-1:0]      weak_pullup_on,
  output logic                             irq
);

  // ****************************************************************
  // bus request and decode
  // ****************************************************************
  iopcn_pkg::iopcn_apb_req_t req;
  assign req.sel   = psel;
  assign req.en    = penable;
  assign req.write = pwrite;
  assign req.addr  = paddr;
  assign req.wdata = pwdata;

  logic pready_r;
  logic pslverr_r;
  logic [31:0] prdata_r;

  // one wait state: pready rises in the second access cycle
  wire access_pend = req.sel & req.en & ~pready_r;
  wire commit      = req.sel & req.en & pready_r;
  wire do_wr       = commit & req.write;

  wire hit_dir    = (req.addr == `IOPCN_OFS_DIR);
  wire hit_latch  = (req.addr == `IOPCN_OFS_LATCH);
  wire hit_level  = (req.addr == `IOPCN_OFS_LEVEL);
  wire hit_odc    = (req.addr == `IOPCN_OFS_ODC);
  wire hit_ancfg  = (req.addr == `IOPCN_OFS_ANCFG);
  wire hit_cn_lo  = (req.addr == `IOPCN_OFS_CNEN_LO);
  wire hit_cn_hi  = (req.addr == `IOPCN_OFS_CNEN_HI);
  wire hit_pu_lo  = (req.addr == `IOPCN_OFS_PU_LO);
  wire hit_pu_hi  = (req.addr == `IOPCN_OFS_PU_HI);
  wire hit_status = (req.addr == `IOPCN_OFS_STATUS);
  wire hit_mask   = (req.addr == `IOPCN_OFS_MASK);
  wire hit_any    = hit_dir | hit_latch | hit_level | hit_odc | hit_ancfg
                  | hit_cn_lo | hit_cn_hi | hit_pu_lo | hit_pu_hi
                  | hit_status | hit_mask;

  // ****************************************************************
  // control registers
  // ****************************************************************
  logic [`IOPCN_PORT_W-1:0]  pin_direction_r;
  logic [`IOPCN_PORT_W-1:0]  output_latch_r;
  logic [`IOPCN_PORT_W-1:0]  open_drain_select_r;
  logic [`IOPCN_PORT_W-1:0]  analog_pin_config_r;
  logic [`IOPCN_CN_LO_W-1:0] change_notice_enable_low_r;
  logic [`IOPCN_CN_HI_W-1:0] change_notice_enable_high_r;
  logic [`IOPCN_CN_LO_W-1:0] weak_pullup_enable_low_r;
  logic [`IOPCN_CN_HI_W-1:0] weak_pullup_enable_high_r;
  logic [`IOPCN_IRQ_W-1:0]   irq_status_r;
  logic [`IOPCN_IRQ_W-1:0]   irq_mask_r;

  wire [`IOPCN_PORT_W-1:0]  wr_port  = req.wdata[`IOPCN_PORT_W-1:0];
  wire [`IOPCN_CN_LO_W-1:0] wr_cn_lo = req.wdata[`IOPCN_CN_LO_W-1:0];
  wire [`IOPCN_CN_HI_W-1:0] wr_cn_hi = req.wdata[`IOPCN_CN_HI_W-1:0];
  wire [`IOPCN_IRQ_W-1:0]   wr_irq   = req.wdata[`IOPCN_IRQ_W-1:0];

  // writes to the readback address land in the output latch
  wire wr_latch = do_wr & (hit_latch | hit_level);

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      pin_direction_r     <= `IOPCN_RST_DIR;
      output_latch_r      <= `IOPCN_RST_LATCH;
      open_drain_select_r <= `IOPCN_RST_ODC;
      analog_pin_config_r <= `IOPCN_RST_ANCFG;
    end
    else
    begin
      if (do_wr & hit_dir)
        pin_direction_r <= wr_port;
      if (wr_latch)
        output_latch_r <= wr_port;
      if (do_wr & hit_odc)
        open_drain_select_r <= wr_port;
      if (do_wr & hit_ancfg)
        analog_pin_config_r <= wr_port;
    end
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      change_notice_enable_low_r  <= `IOPCN_RST_CN_LO;
      change_notice_enable_high_r <= `IOPCN_RST_CN_HI;
      weak_pullup_enable_low_r    <= `IOPCN_RST_CN_LO;
      weak_pullup_enable_high_r   <= `IOPCN_RST_CN_HI;
      irq_mask_r                  <= `IOPCN_RST_IRQ;
    end
    else
    begin
      if (do_wr & hit_cn_lo)
        change_notice_enable_low_r <= wr_cn_lo;
      if (do_wr & hit_cn_hi)
        change_notice_enable_high_r <= wr_cn_hi;
      if (do_wr & hit_pu_lo)
        weak_pullup_enable_low_r <= wr_cn_lo;
      if (do_wr & hit_pu_hi)
        weak_pullup_enable_high_r <= wr_cn_hi;
      if (do_wr & hit_mask)
        irq_mask_r <= wr_irq;
    end
  end

  // ****************************************************************
  // pad drive
  // ****************************************************************
  iopcn_pkg::iopcn_pad_t pad_nxt;
  logic [`IOPCN_PORT_W-1:0] pad_out_r;
  logic [`IOPCN_PORT_W-1:0] pad_oe_r;

  wire [`IOPCN_PORT_W-1:0] drive_dir = ~pin_direction_r;

  // open drain only pulls low; high is left to the external pull-up
  assign pad_nxt.out = output_latch_r & ~open_drain_select_r;
  assign pad_nxt.oe  = drive_dir & (~open_drain_select_r | ~output_latch_r);

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      pad_out_r <= {`IOPCN_PORT_W{1'b0}};
      pad_oe_r  <= {`IOPCN_PORT_W{1'b0}};
    end
    else
    begin
      pad_out_r <= pad_nxt.out;
      pad_oe_r  <= pad_nxt.oe;
    end
  end

  // ****************************************************************
  // pin input synchronisers
  // ****************************************************************
  logic [`IOPCN_PORT_W-1:0] pad_meta_r;
  logic [`IOPCN_PORT_W-1:0] pad_sync_r;
  logic [`IOPCN_CN_W-1:0]   cn_meta_r;
  logic [`IOPCN_CN_W-1:0]   cn_sync_r;

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      pad_meta_r <= {`IOPCN_PORT_W{1'b0}};
      pad_sync_r <= {`IOPCN_PORT_W{1'b0}};
      cn_meta_r  <= {`IOPCN_CN_W{1'b0}};
      cn_sync_r  <= {`IOPCN_CN_W{1'b0}};
    end
    else
    begin
      pad_meta_r <= pad_in;
      pad_sync_r <= pad_meta_r;
      cn_meta_r  <= change_notice_input;
      cn_sync_r  <= cn_meta_r;
    end
  end

  // ****************************************************************
  // analog routing
  // ****************************************************************
  // analog config bit clear means the pin is analog
  wire [`IOPCN_PORT_W-1:0] pin_is_analog = ~analog_pin_config_r;

  // readback passes two synchroniser stages, so a read straight
  // after a write or direction change sees the old level
  wire [`IOPCN_PORT_W-1:0] level_view = pad_sync_r & ~pin_is_analog;

  logic [`IOPCN_PORT_W-1:0] adc_connect_r;
  logic [`IOPCN_PORT_W-1:0] adc_use_driven_r;
  logic [`IOPCN_PORT_W-1:0] adc_driven_level_r;

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      adc_connect_r      <= {`IOPCN_PORT_W{1'b0}};
      adc_use_driven_r   <= {`IOPCN_PORT_W{1'b0}};
      adc_driven_level_r <= {`IOPCN_PORT_W{1'b0}};
    end
    else
    begin
      adc_connect_r      <= pin_is_analog;
      adc_use_driven_r   <= pin_is_analog & drive_dir;
      adc_driven_level_r <= pad_nxt.out;
    end
  end

  // ****************************************************************
  // change notification
  // ****************************************************************
  logic [`IOPCN_CN_W-1:0] cn_captured_r;

  wire [`IOPCN_CN_W-1:0] cn_enable = {change_notice_enable_high_r,
                                      change_notice_enable_low_r};
  wire [`IOPCN_CN_W-1:0] cn_mismatch = (cn_sync_r ^ cn_captured_r) & cn_enable;
  wire cn_event = |cn_mismatch;

  // capture follows every pin so that enabling a pin later does
  // not report a stale difference; no sleep gating here
  always_ff @(posedge clock)
  begin
    if (srst)
      cn_captured_r <= {`IOPCN_CN_W{1'b0}};
    else
      cn_captured_r <= cn_sync_r;
  end

  // ****************************************************************
  // interrupt status and line
  // ****************************************************************
  wire [`IOPCN_IRQ_W-1:0] irq_set;
  wire [`IOPCN_IRQ_W-1:0] irq_clr;
  assign irq_set[`IOPCN_IRQ_CN_BIT] = cn_event;
  assign irq_clr = (do_wr & hit_status) ? wr_irq : {`IOPCN_IRQ_W{1'b0}};

  // set beats a write-one clear in the same cycle
  wire [`IOPCN_IRQ_W-1:0] irq_status_nxt = (irq_status_r & ~irq_clr) | irq_set;

  logic irq_r;

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      irq_status_r <= `IOPCN_RST_IRQ;
      irq_r        <= 1'b0;
    end
    else
    begin
      irq_status_r <= irq_status_nxt;
      irq_r        <= |(irq_status_nxt & irq_mask_r);
    end
  end

  // ****************************************************************
  // read mux and bus answer
  // ****************************************************************
  logic [31:0] rd_mux;

  always_comb
  begin
    rd_mux = 32'h0000_0000;
    if (hit_dir)
      rd_mux[`IOPCN_PORT_W-1:0] = pin_direction_r;
    if (hit_latch)
      rd_mux[`IOPCN_PORT_W-1:0] = output_latch_r;
    if (hit_level)
      rd_mux[`IOPCN_PORT_W-1:0] = level_view;
    if (hit_odc)
      rd_mux[`IOPCN_PORT_W-1:0] = open_drain_select_r;
    if (hit_ancfg)
      rd_mux[`IOPCN_PORT_W-1:0] = analog_pin_config_r;
    if (hit_cn_lo)
      rd_mux[`IOPCN_CN_LO_W-1:0] = change_notice_enable_low_r;
    if (hit_cn_hi)
      rd_mux[`IOPCN_CN_HI_W-1:0] = change_notice_enable_high_r;
    if (hit_pu_lo)
      rd_mux[`IOPCN_CN_LO_W-1:0] = weak_pullup_enable_low_r;
    if (hit_pu_hi)
      rd_mux[`IOPCN_CN_HI_W-1:0] = weak_pullup_enable_high_r;
    if (hit_status)
      rd_mux[`IOPCN_IRQ_W-1:0] = irq_status_r;
    if (hit_mask)
      rd_mux[`IOPCN_IRQ_W-1:0] = irq_mask_r;
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
    end
    else
    begin
      pready_r  <= access_pend;
      pslverr_r <= access_pend & ~hit_any;
      prdata_r  <= (access_pend & ~req.write) ? rd_mux : 32'h0000_0000;
    end
  end

  // ****************************************************************
  // pull-up outputs
  // ****************************************************************
  // pull-ups stay as software sets them, even on output pins
  logic [`IOPCN_CN_W-1:0] weak_pullup_on_r;

  always_ff @(posedge clock)
  begin
    if (srst)
      weak_pullup_on_r <= {`IOPCN_CN_W{1'b0}};
    else
      weak_pullup_on_r <= {weak_pullup_enable_high_r,
                           weak_pullup_enable_low_r};
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign prdata           = prdata_r;
  assign pready           = pready_r;
  assign pslverr          = pslverr_r;
  assign pad_out          = pad_out_r;
  assign pad_oe           = pad_oe_r;
  assign adc_connect      = adc_connect_r;
  assign adc_use_driven   = adc_use_driven_r;
  assign adc_driven_level = adc_driven_level_r;
  assign weak_pullup_on   = weak_pullup_on_r;
  assign irq              = irq_r;

endmodule

// *** testbench/iopcn_chk.sv ***
// checker for the port and change-notice block
// assumes it is bound to iopcn_top and sees only its ports
`timescale 1ns/1ns

module iopcn_chk (
  input wire logic        clock,
  input wire logic        srst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [15:0] pad_in,
  input wire logic [15:0] pad_out,
  input wire logic [15:0] pad_oe,
  input wire logic [15:0] adc_connect,
  input wire logic [15:0] adc_use_driven,
  input wire logic [15:0] adc_driven_level,
  input wire logic [29:0] change_notice_input,
  input wire logic [29:0] weak_pullup_on,
  input wire logic        irq
);
  default clocking @(posedge clock); endclocking
  default disable iff (srst);

  // *****
  // quiet-time helpers
  // *****
  logic [3:0]  quiet_r;
  logic [3:0]  quiet_nxt;
  logic [29:0] cn_last_r;
  logic [2:0]  wr_hist_r;
  // any bus activity or pin change restarts the quiet count
  assign quiet_nxt = (psel || change_notice_input != cn_last_r) ? 4'h0 :
                     (quiet_r == 4'hf) ? quiet_r : quiet_r + 4'h1;

  always_ff @(posedge clock)
  begin
    quiet_r   <= srst ? 4'h0 : quiet_nxt;
    cn_last_r <= change_notice_input;
    wr_hist_r <= srst ? 3'h0 : {wr_hist_r[1:0], psel & penable & pready & pwrite};
  end

  a_one_wait: assert property (psel && penable && !$past(penable) |-> !pready ##1 pready)
    else $error("pready not after one wait state");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_idle_quiet: assert property (!pready |-> prdata == 32'h0 && !pslverr)
    else $error("read data or error outside answer");
  a_err_map: assert property (pready |-> pslverr == (paddr > 12'h028 || paddr[1:0] != 2'h0))
    else $error("error response does not match map");
  a_analog_read0: assert property (
    pready && !pwrite && paddr == 12'h008 |-> (prdata[15:0] & adc_connect) == 16'h0)
    else $error("analog pin read back nonzero");
  a_driven_route: assert property ((adc_use_driven & ~adc_connect) == 16'h0)
    else $error("driven level used on unrouted pin");
  a_driven_level: assert property (
    ((adc_driven_level ^ pad_out) & adc_use_driven) == 16'h0)
    else $error("converter level differs from pin drive");
  a_oe_driven: assert property ((adc_connect & pad_oe & ~adc_use_driven) == 16'h0)
    else $error("driven analog pin not fed to converter");
  a_outputs_hold: assert property (
    !$stable({pad_out, pad_oe, weak_pullup_on}) |-> wr_hist_r != 3'h0)
    else $error("pin controls changed without a write");
  a_irq_quiet: assert property (quiet_r >= 4'h7 |-> $stable(irq))
    else $error("interrupt moved with no cause");

  c_err: cover property (pready && pslverr);
  c_irq: cover property ($rose(irq));
  c_level_rd: cover property (pready && !pwrite && paddr == 12'h008);
endmodule

bind iopcn_top iopcn_chk u_chk (.clock(clock), .srst(srst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .pad_in(pad_in),
  .pad_out(pad_out), .pad_oe(pad_oe), .adc_connect(adc_connect),
  .adc_use_driven(adc_use_driven), .adc_driven_level(adc_driven_level),
  .change_notice_input(change_notice_input), .weak_pullup_on(weak_pullup_on), .irq(irq));

// *** testbench/iopcn_pins.sv ***
// external pins: port pads with pull-up resistors, change-notice lines
// assumes the bench says which lines it drives and to what level
`timescale 1ns/1ns

module iopcn_pins (
  input  wire logic [15:0] pad_out,
  input  wire logic [15:0] pad_oe,
  input  wire logic [15:0] ext_level,
  input  wire logic [15:0] ext_drive,
  output logic      [15:0] pad_in,
  input  wire logic [29:0] cn_level,
  input  wire logic [29:0] cn_drive,
  input  wire logic [29:0] weak_pullup_on,
  output logic      [29:0] change_notice_input
);
  // released port lines float up on board resistors, open drain included
  assign pad_in = (pad_oe & pad_out) | (~pad_oe & ~ext_drive) | (~pad_oe & ext_drive & ext_level);
  // undriven lines without pull-up show the inverse of cn_level
  assign change_notice_input = (cn_drive & cn_level) | (~cn_drive & weak_pullup_on) |
                               (~cn_drive & ~weak_pullup_on & ~cn_level);
endmodule

// *** testbench/io_port_change_notify_test.sv ***
// self-checking bench for the port and change-notice block
// assumes an apb master here and the pin model on the far side
`timescale 1ns/1ns
`define CHK(what, exp, got) \
  begin \
    cmp_count++; \
    if ((got) !== (exp)) \
    begin \
      bad_count++; \
      $display("Error %s expected %h seen %h", what, exp, got); \
    end \
  end

module io_port_change_notify_test;
  logic                        clock = 1'b0;
  logic                        srst = 1'b1;
  iopcn_pkg::iopcn_apb_req_t   req = '0;
  logic [31:0]                 prdata, rq, v;
  logic                        pready, pslverr, irq, re;
  logic [15:0]                 pad_in, pad_out, pad_oe, adc_connect, adc_use_driven;
  logic [15:0]                 adc_driven_level, lv;
  logic [15:0]                 ext_level = 16'h0;
  logic [15:0]                 ext_drive = 16'h0;
  logic [29:0]                 cn_in, weak_pullup_on;
  logic [29:0]                 cn_level = 30'h0;
  logic [29:0]                 cn_drive = 30'h0;
  logic [11:0]                 a;
  int                          bad_count = 0;
  int                          cmp_count = 0;

  always #20 clock = ~clock;

  iopcn_top DUT (.clock(clock), .srst(srst), .psel(req.sel), .penable(req.en),
    .pwrite(req.write), .paddr(req.addr), .pwdata(req.wdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pad_in(pad_in), .pad_out(pad_out),
    .pad_oe(pad_oe), .adc_connect(adc_connect), .adc_use_driven(adc_use_driven),
    .adc_driven_level(adc_driven_level), .change_notice_input(cn_in),
    .weak_pullup_on(weak_pullup_on), .irq(irq));
  iopcn_pins u_pins (.pad_out(pad_out), .pad_oe(pad_oe), .ext_level(ext_level),
    .ext_drive(ext_drive), .pad_in(pad_in), .cn_level(cn_level), .cn_drive(cn_drive),
    .weak_pullup_on(weak_pullup_on), .change_notice_input(cn_in));

  task close_out;
    if (bad_count == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // *****
  // bus cycles
  // *****
  // starts on the next edge, so every transfer is followed by an idle cycle
  task apb(input logic wr, input logic [11:0] ad, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    req <= '{1'b1, 1'b0, wr, ad, d};
    @(posedge clock);
    req.en <= 1'b1;
    // pready and the answer are taken at the edge that completes the access
    do
    begin
      @(posedge clock);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rq = prdata;
    re = pslverr;
    req <= '0;
    if (n >= 20)
    begin
      bad_count++;
      close_out;
    end
  endtask

  task pause(input int n);
    repeat (n) @(negedge clock);
  endtask

  function automatic logic [31:0] wmask(input logic [11:0] ad);
    case (ad)
      12'h018, 12'h020: return 32'h3fff;
      12'h028: return 32'h1;
      default: return 32'hffff;
    endcase
  endfunction

  // one change on pin p with given enable and mask
  task cn_try(input int p, input logic en, input logic msk);
    a = (p < 16) ? 12'h014 : 12'h018;
    apb(1'b1, 12'h028, {31'h0, msk});
    apb(1'b1, a, {31'h0, en} << ((p < 16) ? p : p - 16));
    @(posedge clock);
    cn_drive[p] <= 1'b1;
    pause(8);
    `CHK("irq", en & msk, irq);
    apb(1'b0, 12'h024, 32'h0);
    `CHK("status", {31'h0, en}, rq);
    apb(1'b1, a, 32'h0);
    @(posedge clock);
    cn_drive[p] <= 1'b0;
    pause(4);
    apb(1'b1, 12'h024, 32'h1);
    pause(2);
    `CHK("irq clear", 1'b0, irq);
  endtask

  // *****
  // main sequence
  // *****
  initial
  begin
    void'($urandom(39));
    repeat (8) @(posedge clock);
    srst <= 1'b0;
    for (int i = 0; i < 11; i++)
    begin
      apb(1'b0, 12'(4 * i), 32'h0);
      `CHK("reset value", (i == 0) ? 32'hffff : 32'h0, rq);
    end
    apb(1'b1, 12'h100, 32'hffffffff);
    apb(1'b0, 12'h100, 32'h0);
    `CHK("unmapped", {1'b1, 32'h0}, {re, rq});
    for (int i = 0; i < 11; i++)
    begin
      a = 12'(4 * i);
      if (a == 12'h008 || a == 12'h024)
        continue;
      v = $urandom;
      apb(1'b1, a, v);
      apb(1'b0, a, 32'h0);
      `CHK("register", v & wmask(a), rq);
    end
    apb(1'b1, 12'h000, 32'hffff);
    @(posedge clock);
    lv = 16'($urandom);
    ext_level <= lv;
    ext_drive <= 16'hffff;
    v = $urandom;
    apb(1'b1, 12'h010, v);
    pause(4);
    apb(1'b0, 12'h008, 32'h0);
    `CHK("analog readback", {16'h0, lv & v[15:0]}, rq);
    `CHK("converter route", ~v[15:0], adc_connect);
    @(posedge clock);
    ext_drive <= 16'h0;
    apb(1'b1, 12'h01c, 32'h0);
    apb(1'b1, 12'h00c, 32'h0);
    apb(1'b1, 12'h010, 32'h0);
    apb(1'b1, 12'h004, {16'h0, lv});
    apb(1'b1, 12'h000, 32'h0);
    pause(2);
    `CHK("driven to converter", {16'hffff, lv}, {adc_use_driven, adc_driven_level});
    `CHK("push-pull", {16'hffff, lv}, {pad_oe, pad_out});
    apb(1'b1, 12'h00c, 32'hffff);
    pause(2);
    `CHK("open drain", {~lv, 16'h0}, {pad_oe, pad_out});
    apb(1'b1, 12'h010, 32'hffff);
    pause(4);
    apb(1'b0, 12'h008, 32'h0);
    `CHK("open drain level", {16'h0, lv}, rq);
    apb(1'b1, 12'h01c, 32'hffff);
    apb(1'b1, 12'h020, 32'h3fff);
    apb(1'b1, 12'h014, 32'h0);
    apb(1'b1, 12'h018, 32'h0);
    pause(4);
    apb(1'b1, 12'h024, 32'h1);
    pause(2);
    `CHK("pull-ups", 30'h3fffffff, weak_pullup_on);
    cn_try(0, 1'b1, 1'b1);
    cn_try(15, 1'b0, 1'b1);
    cn_try(16, 1'b1, 1'b0);
    cn_try(29, 1'b1, 1'b1);
    repeat (4)
      cn_try($urandom_range(29, 0), 1'($urandom), 1'($urandom));
    close_out;
  end
endmodule
